// ===== ssr_pkg.sv
// ssr_pkg: constants and types for the serial result readout block.
// assumes one 40 MHz system clock; frame pins are sampled on that clock.
package ssr_pkg;
    localparam int RES_BITS = 12;
    localparam int LEAD_ZEROS = 4;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] CNT_MSB = 5'h04;
    localparam logic [4:0] CNT_END = 5'h10;
    localparam logic [3:0] FRAME_LAST = 4'hF;
    localparam logic [11:0] TRIAL_MSB = 12'h0800;
    localparam logic [11:0] CODE_ZERO = 12'h0000;
    localparam logic [3:0] LEAD_CODE = 4'h0;

    typedef enum logic [0:0] {
        SSR_IDLE = 1'b0,
        SSR_FRAME = 1'b1
    } ssr_state_t;

    // successive-approximation working set
    typedef struct packed {
        logic [11:0] sar;
        logic [11:0] mask;
        logic [11:0] trial;
    } ssr_sar_t;

    // offset-binary sar word to twos complement
    function automatic logic [11:0] ssr_twos(input logic [11:0] code);
        ssr_twos = {~code[11], code[10:0]};
    endfunction
endpackage

// ===== ssr_readout.sv
// ssr_readout: select-framed conversion control and serial result shifter.
// assumes cs_n and sclk are synchronous to clk and comp_in answers the
// current dac_trial within one clk cycle.
// Functional notes
// R1 - select going low starts a conversion and holds the sampled input
// R2 - select low frames the transfer; output driven only while framed
// R3 - serial output advances one bit on each serial clock falling edge
// R4 - frame is four zeros, then twelve result bits, most significant first
// R5 - result is twos complement of the signed differential input
// R6 - each serial clock falling edge steps the successive approximation; the code steps only on the first twelve edges
// R7 - zero input sits between all-ones and all-zeros codes
// R8 - most positive code 0111..1, most negative code 1000..0
// R9 - host gives at least sixteen falling edges, then raises select
`timescale 1ns/1ps
module ssr_readout
    import ssr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic comp_in,
    output logic serial_result_out,
    output logic serial_result_oe_n,
    output logic track_hold,
    output logic [11:0] dac_trial,
    output logic [11:0] result,
    output logic conv_done
);
    ssr_state_t state_reg, state_next;
    ssr_sar_t sar_reg, sar_next;
    logic cs_q_reg, cs_q_next;
    logic sclk_q_reg, sclk_q_next;
    logic [4:0] cnt_reg, cnt_next;
    logic out_reg, out_next;
    logic oe_n_reg, oe_n_next;
    logic hold_reg, hold_next;
    logic [11:0] result_reg, result_next;
    logic done_reg, done_next;
    logic cs_fall;
    logic sclk_fall;
    logic [15:0] frame_word;

    // edge detection; pins are already synchronous so no extra stages
    assign cs_fall = cs_q_reg & ~cs_n;
    assign sclk_fall = sclk_q_reg & ~sclk;

    // next-state logic for the whole frame
    always_comb begin
        state_next = state_reg;
        sar_next = sar_reg;
        cnt_next = cnt_reg;
        out_next = 1'b0;
        hold_next = hold_reg;
        result_next = result_reg;
        done_next = 1'b0;
        cs_q_next = cs_n;
        sclk_q_next = sclk;
        // R2 frame gating
        oe_n_next = cs_n;
        frame_word = {LEAD_CODE, ssr_twos(sar_reg.sar)};
        case (state_reg)
            SSR_IDLE: begin
                hold_next = 1'b0;
                // R1 conversion start
                if (cs_fall) begin
                    state_next = SSR_FRAME;
                    hold_next = 1'b1;
                    sar_next.sar = CODE_ZERO;
                    sar_next.mask = TRIAL_MSB;
                    sar_next.trial = TRIAL_MSB;
                    cnt_next = 5'h00;
                end
            end
            SSR_FRAME: begin
                if (cs_n) begin
                    // select raised early aborts the frame; track again
                    state_next = SSR_IDLE;
                    hold_next = 1'b0;
                end else begin
                    // R6 one sar step per falling edge until the mask is empty (first twelve edges)
                    if (sclk_fall && sar_reg.mask != CODE_ZERO) begin
                        sar_next.sar = comp_in ? (sar_reg.sar | sar_reg.mask) : sar_reg.sar;
                        sar_next.mask = sar_reg.mask >> 1;
                        sar_next.trial = sar_next.sar | sar_next.mask;
                        if (sar_next.mask == CODE_ZERO) begin
                            // R5 R7 R8 twos complement result
                            result_next = ssr_twos(sar_next.sar);
                            done_next = 1'b1;
                            hold_next = 1'b0;
                        end
                    end
                    // R3 advance on falling edge, saturating after the frame
                    if (sclk_fall && cnt_reg != CNT_END) begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                    // R4 leading zeros then msb first
                    frame_word = {LEAD_CODE, ssr_twos(sar_next.sar)};
                    if (cnt_next != CNT_END) begin
                        out_next = frame_word[FRAME_LAST - cnt_next[3:0]];
                    end
                end
            end
            default: begin
                state_next = SSR_IDLE;
            end
        endcase
    end

    // register stage; everything resets to the idle, undriven frame
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= SSR_IDLE;
            sar_reg <= '0;
            cnt_reg <= 5'h00;
            out_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            hold_reg <= 1'b0;
            result_reg <= 12'h0000;
            done_reg <= 1'b0;
            cs_q_reg <= 1'b1;
            sclk_q_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sar_reg <= sar_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            hold_reg <= hold_next;
            result_reg <= result_next;
            done_reg <= done_next;
            cs_q_reg <= cs_q_next;
            sclk_q_reg <= sclk_q_next;
        end
    end

    assign serial_result_out = out_reg;
    assign serial_result_oe_n = oe_n_reg;
    assign track_hold = hold_reg;
    assign dac_trial = sar_reg.trial;
    assign result = result_reg;
    assign conv_done = done_reg;

    // checks; they read the sar and frame counter, so they sit beside the logic
    // rather than in the bench, which only sees the pins
    sequence s_start;
        state_reg == SSR_IDLE && cs_fall;
    endsequence

    sequence s_loaded;
        track_hold && dac_trial == TRIAL_MSB && cnt_reg == 5'h00;
    endsequence

    sequence s_abort;
        state_reg == SSR_FRAME && cs_n;
    endsequence

    sequence s_released;
        state_reg == SSR_IDLE && !track_hold && serial_result_oe_n && !serial_result_out;
    endsequence

    a_start_hold: assert property (@(posedge clk) disable iff (rst) // R1
        s_start |=> s_loaded)
        else $error("conversion did not start on select fall");

    a_frame_gate: assert property (@(posedge clk) disable iff (rst) // R2
        $past(cs_n) |-> serial_result_oe_n && !serial_result_out)
        else $error("output driven outside a frame");

    a_bit_stable: assert property (@(posedge clk) disable iff (rst) // R3
        (state_reg == SSR_FRAME && !cs_n && !sclk_fall) |=> $stable(serial_result_out))
        else $error("serial output moved without a falling edge");

    a_lead_zeros: assert property (@(posedge clk) disable iff (rst) // R4
        (state_reg == SSR_FRAME && cnt_reg < CNT_MSB) |-> !serial_result_out)
        else $error("leading bit not zero");

    a_msb_first: assert property (@(posedge clk) disable iff (rst) // R4
        (state_reg == SSR_FRAME && cnt_reg == CNT_MSB && $changed(cnt_reg))
        |-> serial_result_out == ~sar_reg.sar[11])
        else $error("first data bit is not the sign bit");

    a_twos_result: assert property (@(posedge clk) disable iff (rst) // R5
        conv_done |-> result == {~sar_reg.sar[11], sar_reg.sar[10:0]})
        else $error("result not twos complement");

    a_sar_step: assert property (@(posedge clk) disable iff (rst) // R6
        (state_reg == SSR_FRAME && !cs_n && sclk_fall && sar_reg.mask != CODE_ZERO)
        |=> sar_reg.mask == ($past(sar_reg.mask) >> 1))
        else $error("sar did not step on the falling edge");

    a_mid_scale: assert property (@(posedge clk) disable iff (rst) // R7
        (conv_done && sar_reg.sar == 12'h800 |-> result == 12'h000)
        and (conv_done && sar_reg.sar == 12'h7FF |-> result == 12'hFFF))
        else $error("midscale codes wrong");

    a_full_scale: assert property (@(posedge clk) disable iff (rst) // R8
        (conv_done && sar_reg.sar == 12'hFFF |-> result == 12'h7FF)
        and (conv_done && sar_reg.sar == 12'h000 |-> result == 12'h800))
        else $error("full-scale codes wrong");

    // R1 input tracks again once resolved
    a_hold_release: assert property (@(posedge clk) disable iff (rst) // R1
        conv_done |-> !track_hold)
        else $error("hold not released after the last bit");

    // R6 one done per conversion
    a_done_single: assert property (@(posedge clk) disable iff (rst) // R6
        conv_done |=> !conv_done)
        else $error("done held longer than one cycle");

    // R2 select high ends the frame
    a_abort_idle: assert property (@(posedge clk) disable iff (rst) // R2
        s_abort |=> s_released)
        else $error("frame not ended by select going high");

    // R4 zero after the last bit
    a_tail_zero: assert property (@(posedge clk) disable iff (rst) // R4
        (state_reg == SSR_FRAME && cnt_reg == CNT_END) |-> !serial_result_out)
        else $error("bit after the frame not zero");

    // R2 enable follows select low
    a_oe_follow: assert property (@(posedge clk) disable iff (rst) // R2
        (!$past(cs_n) && !$past(rst)) |-> !serial_result_oe_n)
        else $error("output not enabled inside a frame");
endmodule

// ===== ssr_comp_model.sv
// ssr_comp_model: behavioural comparator with a held analog input code.
// assumes dac_trial is offset binary and the bench sets vin_code.
`timescale 1ns/1ps
module ssr_comp_model
    import ssr_pkg::*;
(
    input wire logic [11:0] vin_code,
    input wire logic track_hold,
    input wire logic [11:0] dac_trial,
    output logic comp_in
);
    logic [11:0] held;
    always @* if (!track_hold) held = vin_code;
    assign comp_in = (held >= dac_trial);
endmodule

// ===== ssr_readout_test.sv
// ssr_readout_test: host-side bench for the serial result readout.
// assumes a 40 MHz clk; the bench acts as host, the model as comparator.
`timescale 1ns/1ps
module ssr_readout_test;
    import ssr_pkg::*;
    logic clk = 0, rst = 1, cs_n = 1, sclk = 0;
    logic [11:0] vin = 12'h0000, trial, result;
    logic comp, out, oe_n, hold, done;
    int miscompares = 0, compares = 0;
    ssr_readout uut (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .comp_in(comp),
        .serial_result_out(out), .serial_result_oe_n(oe_n), .track_hold(hold),
        .dac_trial(trial), .result(result), .conv_done(done));
    ssr_comp_model cmp_m (.vin_code(vin), .track_hold(hold), .dac_trial(trial), .comp_in(comp));
    // 25 ns period
    initial forever #12.5 clk = ~clk;
    task tick;
        @(posedge clk);
        #2;
    endtask
    task cmp_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task cmp_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask
    // one framed transfer of nf falls; input changes after hold to test the hold
    task do_frame(input logic [11:0] v, input int nf, output logic [15:0] f,
        output logic d);
        d = 0;
        f = 16'hFFFF;
        vin = {~v[11], v[10:0]};
        cs_n = 0;
        tick;
        tick;
        vin = ~vin;
        cmp_flag(oe_n, 1'b0);
        cmp_flag(hold, 1'b1);
        cmp_word({4'h0, trial}, {4'h0, TRIAL_MSB});
        f[15] = out;
        for (int i = 1; i <= nf; i++) begin
            sclk = 1;
            tick;
            sclk = 0;
            tick;
            // done stands only in the cycle after the fall edge
            d = d | done;
            tick;
            if (i < 16) f[15 - i] = out;
            else cmp_flag(out, 1'b0);
        end
        // host releases select after the frame
        cs_n = 1;
        tick;
        tick;
        cmp_flag(oe_n, 1'b1);
        cmp_flag(out, 1'b0);
        cmp_flag(hold, 1'b0);
    endtask
    // full frames over boundary codes plus one mid-range code (05A3)
    task test_codes;
        logic [11:0] tbl [5];
        logic [15:0] f;
        logic d;
        tbl = '{12'h0000, 12'h0FFF, 12'h07FF, 12'h0800, 12'h05A3};
        for (int i = 0; i < 5; i++) begin
            do_frame(tbl[i], 16, f, d);
            cmp_word(f, {4'h0, tbl[i]});
            cmp_word({4'h0, result}, {4'h0, tbl[i]});
            cmp_flag(d, 1'b1);
        end
        $display("test_codes done");
    endtask
    // select raised mid-frame, then a new frame at once
    task test_abort;
        logic [15:0] f;
        logic d;
        do_frame(12'h0123, 8, f, d);
        cmp_word(f[15:8], 16'h0001);
        cmp_flag(d, 1'b0);
        cmp_word({4'h0, result}, 16'h05A3);
        do_frame(12'h0ABC, 16, f, d);
        cmp_word(f, 16'h0ABC);
        $display("test_abort done");
    endtask
    task stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #50000;
        miscompares++;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        #2 rst = 0;
        test_codes;
        test_abort;
        stop_test;
    end
endmodule
